// file: hdl/rhp_port_state.v
// root hub port state bits with avalon-mm register slave and interrupt
//
// Summary of operation
// - a set-suspend write to an enabled port sets the suspended flag, bit 2.
// - suspended flag clears when resume interval ends, with suspend change.
// - suspended flag is never set while no device is connected.
// - suspended flag clears at port reset end or controller resume state.
// - a downstream resume is passed to the host controller only while the port is suspended.
// - writing one to bit 2 suspends an enabled port; writing zero does nothing.
// - set-suspend to a disconnected port sets connect change instead.
// - enabled flag clears on fault events, setting enable change flag.
// - enabled flag never set while no device is connected.
// - enabled flag set when port reset or resume completes.
// - writing one to bit 1 enables; disconnected sets connect change.
// - bit 0 reads live connection state of the downstream port.
// - writing one to bit 0 clears the enabled flag.
// - connected flag is unaffected by port status writes; port control bit 0 forces it.
// - connected flag reads one for a non-removable port.
// - writing one to bit 3 starts resume only while suspended.
// - set-reset on disconnected port sets connect change; reset flag clears at end.
`timescale 1ns/1ns
`default_nettype none
`include "rhp_regs.vh"
module rhp_port_state (
  input  wire        clk_sys_in,
  input  wire        rstn_in,
  input  wire [7:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  input  wire        dev_attached_in,
  input  wire        dev_resume_in,
  input  wire        overcurrent_in,
  input  wire        port_power_in,
  input  wire        ctrl_resume_state_in,
  output reg         port_reset_sig_out,
  output reg         port_resume_sig_out,
  output reg         port_enabled_out,
  output reg         upstream_resume_out,
  output reg         irq_out
);
  // =========================================================
  // reset release and pin synchronisers
  reg  [1:0] rst_sync_r;
  wire       rstn = rst_sync_r[1];
  reg  [4:0] pin_s1_r;
  reg  [4:0] pin_s2_r;
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  always @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
    end else begin
      pin_s1_r <= {ctrl_resume_state_in, port_power_in, overcurrent_in,
                   dev_resume_in, dev_attached_in};
      pin_s2_r <= pin_s1_r;
    end
  end
  wire attached_s   = pin_s2_r[0];
  wire dev_resume_s = pin_s2_r[1];
  wire ovc_s        = pin_s2_r[2];
  wire power_s      = pin_s2_r[3];
  wire ctrl_res_s   = pin_s2_r[4];

  // =========================================================
  // register state
  reg        port_suspended_flag_r;
  reg        port_enabled_flag_r;
  reg        port_reset_flag_r;
  reg        resuming_r;
  reg [15:0] timer_r;
  reg [31:0] int_status_r;
  reg [31:0] int_mask_r;
  reg [1:0]  port_ctrl_r;
  reg        attached_d_r;
  reg        acc_done_r;

  function sel;
    input [7:0] a;
    input [7:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  // connected flag: live state or forced for non-removable port
  wire connected_device_flag = attached_s |
       port_ctrl_r[`RHP_BIT_NONREMOVABLE];

  wire acc    = (avs_read_in | avs_write_in) & ~acc_done_r;
  wire wr     = avs_write_in & ~acc_done_r & avs_byteenable_in[0];
  wire wr_ps  = wr & sel(avs_address_in, `RHP_OFS_PORT_STATUS);
  wire wd_clren   = wr_ps & avs_writedata_in[`RHP_BIT_CCS_CLREN];
  wire wd_seten   = wr_ps & avs_writedata_in[`RHP_BIT_PES_SETEN];
  wire wd_setsusp = wr_ps & avs_writedata_in[`RHP_BIT_PSS_SETSUSP];
  wire wd_clrsusp = wr_ps & avs_writedata_in[`RHP_BIT_CLRSUSP];
  wire wd_setrst  = wr_ps & avs_writedata_in[`RHP_BIT_PRS_SETRST];
  wire wr_is  = avs_write_in & ~acc_done_r &
                sel(avs_address_in, `RHP_OFS_INT_STATUS);

  // =========================================================
  // port event decode
  wire disconnect  = attached_d_r & ~connected_device_flag;
  wire fault       = ovc_s | ~power_s | disconnect |
                     port_ctrl_r[`RHP_BIT_OPEN_BUS_ERR];
  wire timer_zero  = (timer_r == 16'h0000);
  wire resume_end  = resuming_r & timer_zero;
  wire reset_end   = port_reset_flag_r & timer_zero;
  wire start_res   = wd_clrsusp & port_suspended_flag_r &
                     ~resuming_r;
  wire start_rst   = wd_setrst & connected_device_flag &
                     ~port_reset_flag_r;
  wire bad_cmd     = (wd_seten | wd_setsusp | wd_setrst) &
                     ~connected_device_flag;
  wire pes_clr_ev  = port_enabled_flag_r & fault;

  wire [31:0] ev_set = ({31'h0, bad_cmd}        << `RHP_BIT_CSC)  |
                       ({31'h0, disconnect}     << `RHP_BIT_CSC)  |
                       ({31'h0, pes_clr_ev}     << `RHP_BIT_PESC) |
                       ({31'h0, resume_end}     << `RHP_BIT_SUSPEND_STATUS_CHANGE_FLAG) |
                       ({31'h0, reset_end}      << `RHP_BIT_RESET_STATUS_CHANGE_FLAG);

  // =========================================================
  // timer load values, cut to the timer width on purpose
  localparam [31:0] RESUME_LOAD_W = `RHP_RESUME_CYC;
  localparam [31:0] RESET_LOAD_W  = `RHP_RESET_CYC;
  localparam [15:0] RESUME_LOAD   = RESUME_LOAD_W[15:0];
  localparam [15:0] RESET_LOAD    = RESET_LOAD_W[15:0];

  // =========================================================
  // attach history for disconnect detection
  always @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      attached_d_r <= 1'b0;
    end else begin
      attached_d_r <= connected_device_flag;
    end
  end

  // =========================================================
  // shared interval timer: a reset start reloads it even while resume runs
  reg [15:0] timer_nxt;
  always @* begin
    timer_nxt = timer_r;
    if (!timer_zero) begin
      timer_nxt = timer_r - 16'h0001;
    end
    if (start_res) begin
      timer_nxt = RESUME_LOAD;
    end
    if (start_rst) begin
      timer_nxt = RESET_LOAD;
    end
  end

  always @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      timer_r <= 16'h0000;
    end else begin
      timer_r <= timer_nxt;
    end
  end

  // =========================================================
  // suspended flag
  reg port_suspended_flag_nxt;
  always @* begin
    port_suspended_flag_nxt = port_suspended_flag_r;
    if (resume_end | reset_end | ctrl_res_s) begin
      port_suspended_flag_nxt = 1'b0;
    end else if (~connected_device_flag) begin
      port_suspended_flag_nxt = 1'b0;
    end else if (wd_setsusp & port_enabled_flag_r) begin
      port_suspended_flag_nxt = 1'b1;
    end
  end

  always @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      port_suspended_flag_r <= 1'b0;
    end else begin
      port_suspended_flag_r <= port_suspended_flag_nxt;
    end
  end

  // =========================================================
  // resume signalling in progress
  reg resuming_nxt;
  always @* begin
    resuming_nxt = resuming_r;
    if (resume_end | reset_end | ctrl_res_s | ~connected_device_flag) begin
      resuming_nxt = 1'b0;
    end
    if (start_res) begin
      resuming_nxt = 1'b1;
    end
  end

  always @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      resuming_r <= 1'b0;
    end else begin
      resuming_r <= resuming_nxt;
    end
  end

  // =========================================================
  // port reset flag
  reg port_reset_flag_nxt;
  always @* begin
    port_reset_flag_nxt = port_reset_flag_r;
    if (start_rst) begin
      port_reset_flag_nxt = 1'b1;
    end else if (reset_end) begin
      port_reset_flag_nxt = 1'b0;
    end
  end

  always @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      port_reset_flag_r <= 1'b0;
    end else begin
      port_reset_flag_r <= port_reset_flag_nxt;
    end
  end

  // =========================================================
  // enabled flag: any clear cause wins over any set cause
  reg port_enabled_flag_nxt;
  always @* begin
    port_enabled_flag_nxt = port_enabled_flag_r;
    if (~connected_device_flag) begin
      port_enabled_flag_nxt = 1'b0;
    end else if (fault) begin
      port_enabled_flag_nxt = 1'b0;
    end else if (wd_clren) begin
      port_enabled_flag_nxt = 1'b0;
    end else if (reset_end | resume_end) begin
      port_enabled_flag_nxt = 1'b1;
    end else if (wd_seten) begin
      port_enabled_flag_nxt = 1'b1;
    end
  end

  always @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      port_enabled_flag_r <= 1'b0;
    end else begin
      port_enabled_flag_r <= port_enabled_flag_nxt;
    end
  end

  // =========================================================
  // interrupt status, mask and control registers
  always @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      int_status_r <= `RHP_RST_VAL;
      int_mask_r   <= `RHP_RST_VAL;
      port_ctrl_r  <= 2'h0;
    end else begin
      // set wins over write-one-to-clear
      int_status_r <= (int_status_r &
                       ~(wr_is ? avs_writedata_in : 32'h0)) | ev_set;
      if (avs_write_in & ~acc_done_r &
          sel(avs_address_in, `RHP_OFS_INT_MASK)) begin
        int_mask_r <= avs_writedata_in;
      end
      if (wr & sel(avs_address_in, `RHP_OFS_PORT_CTRL)) begin
        port_ctrl_r <= avs_writedata_in[1:0];
      end
    end
  end

  // =========================================================
  // avalon slave: one wait cycle, answer on the second cycle
  reg [31:0] rd_mux;
  always @* begin
    case (avs_address_in)
      `RHP_OFS_PORT_STATUS: rd_mux = {11'h000, int_status_r[20:16],
                                      11'h000, port_reset_flag_r, 1'b0,
                                      port_suspended_flag_r,
                                      port_enabled_flag_r,
                                      connected_device_flag};
      `RHP_OFS_INT_STATUS:  rd_mux = int_status_r;
      `RHP_OFS_INT_MASK:    rd_mux = int_mask_r;
      `RHP_OFS_PORT_CTRL:   rd_mux = {30'h0, port_ctrl_r};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      acc_done_r          <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end else begin
      acc_done_r          <= acc;
      avs_waitrequest_out <= ~acc;
      if (avs_read_in & ~acc_done_r) begin
        avs_readdata_out <= rd_mux;
      end
    end
  end

  // =========================================================
  // port-side outputs
  always @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      port_reset_sig_out  <= 1'b0;
      port_resume_sig_out <= 1'b0;
      port_enabled_out    <= 1'b0;
      upstream_resume_out <= 1'b0;
      irq_out             <= 1'b0;
    end else begin
      port_reset_sig_out  <= port_reset_flag_r;
      port_resume_sig_out <= resuming_r;
      port_enabled_out    <= port_enabled_flag_r;
      upstream_resume_out <= dev_resume_s & port_suspended_flag_r;
      irq_out             <= |(int_status_r & int_mask_r);
    end
  end
endmodule // rhp_port_state
`default_nettype wire

// file: shared/rhp_regs.vh
// register map, field positions and timing counts for the root hub port bits
`ifndef RHP_REGS_VH
`define RHP_REGS_VH
`define RHP_OFS_PORT_STATUS  8'h54
`define RHP_OFS_INT_STATUS   8'h58
`define RHP_OFS_INT_MASK     8'h5C
`define RHP_OFS_PORT_CTRL    8'h60
`define RHP_BIT_CCS_CLREN    0
`define RHP_BIT_PES_SETEN    1
`define RHP_BIT_PSS_SETSUSP  2
`define RHP_BIT_CLRSUSP      3
`define RHP_BIT_PRS_SETRST   4
`define RHP_BIT_CSC          16
`define RHP_BIT_PESC         17
`define RHP_BIT_SUSPEND_STATUS_CHANGE_FLAG         18
`define RHP_BIT_RESET_STATUS_CHANGE_FLAG         20
`define RHP_BIT_NONREMOVABLE 0
`define RHP_BIT_OPEN_BUS_ERR 1
`define RHP_RESUME_US        20
`define RHP_RESET_US         10
`define RHP_CLK_MHZ          100
`define RHP_RESUME_CYC       (`RHP_RESUME_US * `RHP_CLK_MHZ)
`define RHP_RESET_CYC        (`RHP_RESET_US * `RHP_CLK_MHZ)
`define RHP_RST_VAL          32'h0000_0000
`endif

// file: tb/rhp_port_state_sva.sv
// protocol and port state assertions for the root hub port block
`timescale 1ns/1ns
`default_nettype none
module rhp_port_state_sva (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic dev_attached_in,
  input wire logic dev_resume_in,
  input wire logic port_reset_sig_out,
  input wire logic port_resume_sig_out,
  input wire logic port_enabled_out,
  input wire logic upstream_resume_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  a_wait_one_cycle: assert property (!avs_waitrequest_out |=>
    avs_waitrequest_out) else $error("waitrequest low too long");
  a_wait_answers: assert property ((avs_read_in || avs_write_in) &&
    avs_waitrequest_out |=> !avs_waitrequest_out) else $error("no answer");
  a_reset_holds: assert property ($rose(port_reset_sig_out) |->
    port_reset_sig_out[*8]) else $error("port reset too short");
  a_reset_enables: assert property ($fell(port_reset_sig_out) |->
    ##[0:2] port_enabled_out) else $error("no enable after reset");
  a_resume_holds: assert property ($rose(port_resume_sig_out) |->
    port_resume_sig_out[*8]) else $error("resume too short");
  a_resume_enables: assert property ($fell(port_resume_sig_out) |->
    ##[0:2] port_enabled_out) else $error("no enable after resume");
  a_up_resume: assert property (upstream_resume_out |->
    $past(dev_resume_in, 3) || $past(dev_resume_in, 4))
    else $error("resume passed up without cause");
  a_unplug_off: assert property ((!dev_attached_in)[*8] |->
    !port_enabled_out) else $error("enabled while unplugged");
endmodule // rhp_port_state_sva
bind rhp_port_state rhp_port_state_sva chk_i (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
  .dev_attached_in(dev_attached_in), .dev_resume_in(dev_resume_in),
  .port_reset_sig_out(port_reset_sig_out),
  .port_resume_sig_out(port_resume_sig_out),
  .port_enabled_out(port_enabled_out),
  .upstream_resume_out(upstream_resume_out));
`default_nettype wire

// file: tb/rhp_usb_dev.sv
// usb device model on the downstream port: attach and remote wake
`timescale 1ns/1ns
`default_nettype none
module rhp_usb_dev (
  input  wire logic clk_in,
  input  wire logic plug_in,
  input  wire logic wake_in,
  output var  logic attached_out,
  output var  logic resume_out
);
  initial attached_out = 1'b0;
  initial resume_out = 1'b0;
  // a detached device cannot signal resume
  always @(posedge clk_in) begin
    attached_out <= plug_in;
    resume_out <= plug_in & wake_in;
  end
endmodule // rhp_usb_dev
`default_nettype wire

// file: tb/root_hub_port_state_bits_bench.sv
// self-checking bench for the root hub port state block
`timescale 1ns/1ns
`default_nettype none
module root_hub_port_state_bits_bench;
  logic        clk_sys_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [7:0]  avs_address_in = 8'h00;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0]  avs_byteenable_in = 4'hF;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        dev_attached_in;
  logic        dev_resume_in;
  logic        overcurrent_in = 1'b0;
  logic        port_power_in = 1'b1;
  logic        ctrl_resume_state_in = 1'b0;
  logic        port_reset_sig_out;
  logic        port_resume_sig_out;
  logic        port_enabled_out;
  logic        upstream_resume_out;
  logic        irq_out;
  logic        plug = 1'b0;
  logic        wake = 1'b0;
  logic [31:0] rdat;
  logic [15:0] seed = 16'h76C0;
  int          error_cnt = 0;
  int          checks = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  rhp_port_state dut (.*);
  rhp_usb_dev dev_i (.clk_in(clk_sys_in), .plug_in(plug), .wake_in(wake),
    .attached_out(dev_attached_in), .resume_out(dev_resume_in));
  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic finish_test;
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_writedata_in <= d;
    do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
    rdat = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic ex(input logic [7:0] a, input logic [31:0] m, e);
    bus(a, 1'b0, 32'h0);
    chk(rdat & m, e);
  endtask
  initial begin
    cy(3);
    rstn_in <= 1'b1;
    cy(4);
    ex(8'h54, 32'h0000001F, 32'h0);
    bus(8'h5C, 1'b1, 32'h00170000);
    bus(8'h54, 1'b1, 32'h2);
    ex(8'h54, 32'h00010003, 32'h00010000);
    chk(32'(irq_out), 32'h1);
    bus(8'h58, 1'b1, 32'h00010000);
    cy(2);
    chk(32'(irq_out), 32'h0);
    bus(8'h54, 1'b1, 32'h4);
    ex(8'h54, 32'h00010004, 32'h00010000);
    plug <= 1'b1;
    cy(8);
    bus(8'h54, 1'b1, 32'h1);
    ex(8'h54, 32'h3, 32'h1);
    bus(8'h54, 1'b1, 32'h10);
    cy(1010);
    ex(8'h54, 32'h00100012, 32'h00100002);
    bus(8'h54, 1'b1, 32'h4);
    bus(8'h54, 1'b1, 32'h0);
    ex(8'h54, 32'h6, 32'h6);
    wake <= 1'b1;
    cy(8);
    chk(32'(upstream_resume_out), 32'h1);
    wake <= 1'b0;
    bus(8'h54, 1'b1, 32'h8);
    cy(2010);
    ex(8'h54, 32'h00040006, 32'h00040002);
    bus(8'h54, 1'b1, 32'h8);
    cy(4);
    chk(32'(port_resume_sig_out), 32'h0);
    bus(8'h54, 1'b1, 32'h1);
    ex(8'h54, 32'h2, 32'h0);
    bus(8'h54, 1'b1, 32'h2);
    overcurrent_in <= 1'b1;
    cy(8);
    ex(8'h54, 32'h00020002, 32'h00020000);
    overcurrent_in <= 1'b0;
    bus(8'h54, 1'b1, 32'h2);
    bus(8'h54, 1'b1, 32'h4);
    ctrl_resume_state_in <= 1'b1;
    cy(8);
    ctrl_resume_state_in <= 1'b0;
    ex(8'h54, 32'h4, 32'h0);
    cy(2010);
    plug <= 1'b0;
    cy(8);
    bus(8'h60, 1'b1, 32'h1);
    ex(8'h54, 32'h1, 32'h1);
    bus(8'h60, 1'b1, 32'h0);
    ex(8'h54, 32'h1, 32'h0);
    // unmapped space: random writes ignored, reads give zero
    repeat (16) begin
      seed = lf(seed);
      bus(8'h70, 1'b1, {seed, ~seed});
      ex(8'h70, 32'hFFFFFFFF, 32'h0);
    end
    finish_test;
  end
  initial begin
    cy(20000);
    error_cnt++;
    finish_test;
  end
endmodule // root_hub_port_state_bits_bench
`default_nettype wire
